// ---- fpwp_params.svh ----
// Purpose: Constants for the program flash page write-protect block.
// Assumes: APB with 32-bit data, 20 MHz clock.
// Notes: Offsets are byte addresses of aligned words.
//
// Summary of operation
// [RULE1] Unlock bit high allows register modification.
// [RULE2] Unlock bit only clearable; reset sets it.
// [RULE3] Zero boundary disables all write protection.
// [RULE4] Boundary is fixed upper part plus field.
// [RULE5] Page holding boundary and below protected.
// [RULE6] Writes need completed key unlock sequence.
// [RULE7] Refuse program or erase inside protected range.
`ifndef FPWP_PARAMS_SVH
`define FPWP_PARAMS_SVH
`define FPWP_OFS_PROTECT 12'h000
`define FPWP_OFS_KEY 12'h004
`define FPWP_OFS_STATUS 12'h008
`define FPWP_UNLOCK_POS 31
`define FPWP_RST_PROTECT 32'h8000_0000
`define FPWP_RST_UNLOCK 1'b1
`define FPWP_RST_BOUND 24'h00_0000
`define FPWP_BOUND_WMASK 24'hff_c000
`define FPWP_STAT_REFUSED_POS 2
`define FPWP_BOUND_W 24
`define FPWP_UPPER_BYTE 8'h1d
`define FPWP_PAGE_BITS 14
`define FPWP_KEY1 32'haa99_6655
`define FPWP_KEY2 32'h5566_99aa
`endif

// ---- fpwp_pkg.sv ----
// Purpose: Types for the program flash page write-protect block.
// Assumes: Constants come from fpwp_params.svh.
// Notes: Only the key sequence state lives here.
`default_nettype none
package fpwp_pkg;
    typedef enum logic [1:0] {
        FPWP_KEY_IDLE = 2'b00,
        FPWP_KEY_ONE = 2'b01,
        FPWP_KEY_OPEN = 2'b10
    } fpwp_key_t;
endpackage
`default_nettype wire

// ---- fpwp_range_chk.sv ----
// Purpose: Combinational check of a flash address against the boundary.
// Assumes: Addresses are 32-bit physical addresses.
// Notes: Page granularity is set by the page-size macro.
`timescale 1ns/1ps
`default_nettype none
`include "fpwp_params.svh"
module fpwp_range_chk (
    input wire logic [23:0] i_bound,
    input wire logic [31:0] i_addr,
    output logic o_protected
);
    logic [31:0] bound_addr;
    logic [31:0] page_top;
    always_comb begin
        bound_addr = {`FPWP_UPPER_BYTE, i_bound}; // [RULE4]
        // Round the boundary up to the end of its page so that page is covered too.
        page_top = bound_addr | {{(32 - `FPWP_PAGE_BITS){1'b0}}, {`FPWP_PAGE_BITS{1'b1}}}; // [RULE5]
        o_protected = (i_bound != 24'h000000) && (i_addr[31:24] == `FPWP_UPPER_BYTE)
            && (i_addr <= page_top); // [RULE3]
    end
endmodule // fpwp_range_chk
`default_nettype wire

// ---- fpwp_top.sv ----
// Purpose: Program flash page write-protect register with APB access and op gate.
// Assumes: One clock; flash controller presents one op request at a time.
// Notes: Writes need two key words in a row; any other bus write disarms the key.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fpwp_params.svh"
module fpwp_top (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_op_req,
    input wire logic [31:0] i_op_addr,
    output logic o_op_grant,
    output logic o_op_refuse
);
    logic unlock_r;
    logic [23:0] bound_r;
    fpwp_pkg::fpwp_key_t key_r;
    logic refused_r;
    logic hit;
    logic setup;
    logic wr;
    logic key_open;
    logic key1_wr;
    logic key2_wr;
    logic prot_wr;
    logic stat_wr;
    logic unmapped;
    logic [23:0] wr_bound;

    // Register decode is shared by the bus logic and the checks below.
    function automatic logic fpwp_is_reg(input logic [11:0] addr, input logic [11:0] ofs);
        fpwp_is_reg = (addr == ofs);
    endfunction

    assign setup = i_psel && !i_penable;
    // Writes take effect in the access cycle; the slave answers with no wait state.
    assign wr = i_psel && i_penable && i_pwrite;
    assign key_open = (key_r == fpwp_pkg::FPWP_KEY_OPEN);
    assign key1_wr = wr && fpwp_is_reg(i_paddr, `FPWP_OFS_KEY) && (i_pwdata == `FPWP_KEY1);
    assign key2_wr = wr && fpwp_is_reg(i_paddr, `FPWP_OFS_KEY) && (i_pwdata == `FPWP_KEY2);
    assign prot_wr = wr && fpwp_is_reg(i_paddr, `FPWP_OFS_PROTECT);
    assign stat_wr = wr && fpwp_is_reg(i_paddr, `FPWP_OFS_STATUS);
    assign unmapped = !fpwp_is_reg(i_paddr, `FPWP_OFS_PROTECT)
        && !fpwp_is_reg(i_paddr, `FPWP_OFS_KEY) && !fpwp_is_reg(i_paddr, `FPWP_OFS_STATUS);
    // Low boundary bits are read-only zero, so the boundary is always page aligned.
    assign wr_bound = i_pwdata[23:0] & `FPWP_BOUND_WMASK;

    fpwp_range_chk u_chk (
        .i_bound(bound_r),
        .i_addr(i_op_addr),
        .o_protected(hit)
    );

    // Key sequence: first word, then second word, then one register write consumes it.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            key_r <= fpwp_pkg::FPWP_KEY_IDLE;
        end else if (wr) begin
            // Any write that breaks the sequence disarms it, so a stray store cannot open it.
            unique case (key_r)
                fpwp_pkg::FPWP_KEY_IDLE: begin
                    if (key1_wr) begin
                        key_r <= fpwp_pkg::FPWP_KEY_ONE; // [RULE6]
                    end
                end
                fpwp_pkg::FPWP_KEY_ONE: begin
                    if (key2_wr) begin
                        key_r <= fpwp_pkg::FPWP_KEY_OPEN; // [RULE6]
                    end else if (key1_wr) begin
                        key_r <= fpwp_pkg::FPWP_KEY_ONE;
                    end else begin
                        key_r <= fpwp_pkg::FPWP_KEY_IDLE;
                    end
                end
                fpwp_pkg::FPWP_KEY_OPEN: begin
                    if (key1_wr) begin
                        key_r <= fpwp_pkg::FPWP_KEY_ONE;
                    end else begin
                        key_r <= fpwp_pkg::FPWP_KEY_IDLE; // [RULE6]
                    end
                end
                default: begin
                    key_r <= fpwp_pkg::FPWP_KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            unlock_r <= `FPWP_RST_UNLOCK; // [RULE2]
            bound_r <= `FPWP_RST_BOUND;
        end else if (prot_wr && key_open && unlock_r) begin // [RULE1] [RULE6]
            bound_r <= wr_bound; // [RULE5]
            // Software can only clear the unlock bit; a one written here keeps it as it is.
            unlock_r <= unlock_r & i_pwdata[`FPWP_UNLOCK_POS]; // [RULE2]
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= 1'b0;
            if (setup) begin
                o_prdata <= 32'h0000_0000;
                unique case (i_paddr)
                    `FPWP_OFS_PROTECT: o_prdata <= {unlock_r, 7'h00, bound_r};
                    `FPWP_OFS_KEY: o_prdata <= 32'h0000_0000;
                    `FPWP_OFS_STATUS: o_prdata <= {29'h0, refused_r, key_r};
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Flash op gate: one-cycle answer to each request.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_op_grant <= 1'b0;
            o_op_refuse <= 1'b0;
        end else begin
            o_op_grant <= i_op_req && !hit;
            o_op_refuse <= i_op_req && hit; // [RULE7]
        end
    end

    // Sticky record of a refused op; a refusal in the clearing cycle wins so none is lost.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            refused_r <= 1'b0;
        end else if (i_op_req && hit) begin
            refused_r <= 1'b1; // [RULE7]
        end else if (stat_wr && i_pwdata[`FPWP_STAT_REFUSED_POS]) begin
            refused_r <= 1'b0;
        end
    end

    sequence s_locked_write;
        !unlock_r ##0 wr;
    endsequence

    AST_LOCK_HOLDS: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_locked_write |=> $stable(bound_r)) // [RULE1]
        else $error("Locked register changed.");
    AST_UNLOCK_NO_SET: assert property (@(posedge i_mclk) disable iff (i_rst)
        !unlock_r |=> !unlock_r) // [RULE2]
        else $error("Unlock bit set without reset.");
    AST_ZERO_OFF: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_op_req && bound_r == 24'h000000) |=> o_op_grant && !o_op_refuse) // [RULE3]
        else $error("Op refused with protection off.");
    AST_BELOW_BOUND: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_op_req && bound_r != 24'h000000 && i_op_addr == {`FPWP_UPPER_BYTE, 24'h000000})
        |=> o_op_refuse) // [RULE4]
        else $error("Lowest flash address not protected.");
    AST_SAME_PAGE: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_op_req && bound_r != 24'h000000
        && i_op_addr[31:`FPWP_PAGE_BITS] == {`FPWP_UPPER_BYTE, bound_r[23:`FPWP_PAGE_BITS]})
        |=> o_op_refuse) // [RULE5]
        else $error("Boundary page not protected.");
    AST_NEED_KEY: assert property (@(posedge i_mclk) disable iff (i_rst)
        (wr && i_paddr == `FPWP_OFS_PROTECT && !key_open) |=> $stable(bound_r)) // [RULE6]
        else $error("Write without key changed register.");
    AST_REFUSE_EXCL: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_op_req && hit) |=> o_op_refuse && !o_op_grant && refused_r) // [RULE7]
        else $error("Protected op not refused.");
    AST_READY_ONE: assert property (@(posedge i_mclk) disable iff (i_rst)
        setup |=> o_pready ##1 !o_pready)
        else $error("Ready not a single cycle.");

    sequence s_keyed_write;
        key_open ##0 unlock_r ##0 prot_wr;
    endsequence

    sequence s_refuse_and_clear;
        i_op_req ##0 hit ##0 stat_wr ##0 i_pwdata[`FPWP_STAT_REFUSED_POS];
    endsequence

    // Checks on the key sequence, the stored boundary, the refusal record, the op answers, unmapped-address errors and reset values.
    AST_KEYED_WRITE: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_keyed_write |=> bound_r == $past(wr_bound)) // [RULE1]
        else $error("Keyed write did not store the boundary.");
    AST_KEY_CONSUMED: assert property (@(posedge i_mclk) disable iff (i_rst)
        prot_wr |=> key_r == fpwp_pkg::FPWP_KEY_IDLE) // [RULE6]
        else $error("Key still open after a register write.");
    AST_KEY_ORDER: assert property (@(posedge i_mclk) disable iff (i_rst)
        (key2_wr && key_r != fpwp_pkg::FPWP_KEY_ONE) |=> !key_open) // [RULE6]
        else $error("Key opened out of order.");
    AST_KEY_OPENS: assert property (@(posedge i_mclk) disable iff (i_rst)
        (key2_wr && key_r == fpwp_pkg::FPWP_KEY_ONE) |=> key_open) // [RULE6]
        else $error("Key did not open after both words.");
    AST_LOW_BITS_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)
        1'b1 |-> bound_r[`FPWP_PAGE_BITS-1:0] == 14'h0000) // [RULE5]
        else $error("Read-only boundary bits not zero.");
    AST_SET_WINS: assert property (@(posedge i_mclk) disable iff (i_rst)
        s_refuse_and_clear |=> refused_r) // [RULE7]
        else $error("Refusal lost to a clear.");
    AST_CLEAR_FLAG: assert property (@(posedge i_mclk) disable iff (i_rst)
        (stat_wr && i_pwdata[`FPWP_STAT_REFUSED_POS] && !(i_op_req && hit))
        |=> !refused_r) // [RULE7]
        else $error("Refusal record not cleared.");
    AST_GRANT_OPEN: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_op_req && !hit) |=> o_op_grant && !o_op_refuse) // [RULE7]
        else $error("Unprotected op not granted.");
    AST_OP_QUIET: assert property (@(posedge i_mclk) disable iff (i_rst)
        !i_op_req |=> !o_op_grant && !o_op_refuse)
        else $error("Op answer without a request.");
    AST_UNMAPPED_ERR: assert property (@(posedge i_mclk) disable iff (i_rst)
        (setup && unmapped) |=> o_pready && o_pslverr)
        else $error("Unmapped access not flagged.");
    AST_RESET_STATE: assert property (@(posedge i_mclk)
        $fell(i_rst) |-> unlock_r && bound_r == `FPWP_RST_BOUND && !refused_r) // [RULE2]
        else $error("State not at reset values after reset.");
endmodule // fpwp_top
`default_nettype wire

// ---- fpwp_bench.sv ----
// Purpose: Self-checking bench for the page write-protect block.
// Assumes: Zero-wait APB answer and a one-cycle op answer.
// Notes: Page ends are worked out from a 16 KB page.
`timescale 1ns/1ps
`default_nettype none
`include "fpwp_params.svh"
module fpwp_bench;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, req = 0, err, rdy, serr, gnt, ref_o;
    logic [11:0] pa = 0;
    logic [31:0] pd = 0, oa = 0, rd, prd;
    int fail_count = 0, total_checks = 0, cyc = 0;
    fpwp_top fpwp_top_i (.i_mclk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(serr), .i_op_req(req), .i_op_addr(oa), .o_op_grant(gnt),
        .o_op_refuse(ref_o));
    initial begin
        forever #25 clk = ~clk;
    end
    // A hung handshake ends the run here rather than stalling forever.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            $display("unexpected at %0t: run timed out", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        rd = prd;
        err = serr;
        psel <= 0;
        pen <= 0;
    endtask
    task automatic wr_prot(input logic [31:0] d);
        apb(1, `FPWP_OFS_KEY, `FPWP_KEY1);
        apb(1, `FPWP_OFS_KEY, `FPWP_KEY2);
        apb(1, `FPWP_OFS_PROTECT, d);
    endtask
    task automatic rd_prot(input logic [31:0] exp);
        apb(0, `FPWP_OFS_PROTECT, 32'h0);
        chk(rd, exp);
    endtask
    task automatic rd_stat(input logic [31:0] exp);
        apb(0, `FPWP_OFS_STATUS, 32'h0);
        chk(rd, exp);
    endtask
    task automatic op(input logic [31:0] a, input logic r);
        @(posedge clk);
        req <= 1;
        oa <= a;
        @(posedge clk);
        req <= 0;
        // The answer stands for the one cycle after the request edge.
        @(negedge clk);
        chk({30'h0, gnt, ref_o}, {30'h0, ~r, r});
    endtask
    task automatic test_key();
        rd_prot(`FPWP_RST_PROTECT);
        apb(1, `FPWP_OFS_PROTECT, 32'h8000_8000);
        rd_prot(`FPWP_RST_PROTECT);
        apb(1, `FPWP_OFS_KEY, `FPWP_KEY2);
        apb(1, `FPWP_OFS_KEY, `FPWP_KEY1);
        rd_stat(32'h0000_0001);
        apb(1, `FPWP_OFS_PROTECT, 32'h8000_8000);
        rd_prot(`FPWP_RST_PROTECT);
        $display("key test done");
    endtask
    task automatic test_boundary();
        wr_prot(32'h8000_8123);
        rd_prot(32'h8000_8000);
        op(32'h1d00_0000, 1);
        op(32'h1d00_bfff, 1);
        op(32'h1d00_c000, 0);
        rd_stat(32'h0000_0004);
        apb(1, `FPWP_OFS_STATUS, 32'h0000_0004);
        rd_stat(32'h0000_0000);
        wr_prot(32'h8000_0000);
        op(32'h1d00_0000, 0);
        $display("boundary test done");
    endtask
    task automatic test_lock();
        wr_prot(32'h0000_4000);
        rd_prot(32'h0000_4000);
        wr_prot(32'h8000_8000);
        rd_prot(32'h0000_4000);
        op(32'h1d00_7fff, 1);
        op(32'h1d00_8000, 0);
        $display("lock test done");
    endtask
    task automatic test_reset();
        apb(0, 12'hff0, 32'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd_prot(`FPWP_RST_PROTECT);
        rd_stat(32'h0000_0000);
        $display("reset test done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        test_key();
        test_boundary();
        test_lock();
        test_reset();
        complete_run();
    end
endmodule // fpwp_bench
`default_nettype wire
